// >>> kbc_defines.svh
`ifndef KBC_DEFINES_SVH
`define KBC_DEFINES_SVH
`define KBC_DATA_ADDR      16'h0060
`define KBC_CTRL_ADDR      16'h0064
`define KBC_OBF_BIT        0
`define KBC_IBF_BIT        1
`define KBC_CD_BIT         3
`define KBC_ADDR_CD_BIT    2
`define KBC_STATUS_RESET   8'h00
`define KBC_BYTE_RESET     8'h00
`define KBC_UD_MASK        8'hF4
`endif

// >>> kbc_pkg.sv
package kbc_pkg;
   typedef logic [7:0]  byte_t;
   typedef logic [15:0] ioaddr_t;
   typedef enum logic [1:0] {
      HOST_IDLE   = 2'b00,
      HOST_ACTIVE = 2'b01
   } host_phase_t;
endpackage : kbc_pkg

// >>> kbc_host_if.sv
interface kbc_host_if;
   import kbc_pkg::*;
   logic  wrData;
   logic  wrCmd;
   logic  rdData;
   byte_t wrByte;
   modport decoder (output wrData, output wrCmd, output rdData, output wrByte);
   modport core    (input wrData, input wrCmd, input rdData, input wrByte);
endinterface : kbc_host_if

// >>> kbc_host_decode.sv
`include "kbc_defines.svh"
module kbc_host_decode (
   // clock and reset
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   // isa strobes
   input  wire kbc_pkg::ioaddr_t hostAddr,
   input  wire logic           ioRead_n,
   input  wire logic           ioWrite_n,
   input  wire kbc_pkg::byte_t hostDataIn,
   // decoded events
   kbc_host_if.decoder         evt
);
   import kbc_pkg::*;
   logic wrPrev_r;
   logic rdPrev_r;
   logic isData;
   logic isCtrl;

   assign isData = (hostAddr == `KBC_DATA_ADDR);
   assign isCtrl = (hostAddr == `KBC_CTRL_ADDR);

   // one event per strobe, taken on its falling edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wrPrev_r <= 1'b1;
         rdPrev_r <= 1'b1;
      end else begin
         wrPrev_r <= ioWrite_n;
         rdPrev_r <= ioRead_n;
      end
   end

   assign evt.wrData = wrPrev_r && !ioWrite_n && ioRead_n && isData;
   assign evt.wrCmd  = wrPrev_r && !ioWrite_n && ioRead_n && isCtrl;
   assign evt.rdData = rdPrev_r && !ioRead_n && ioWrite_n && isData;
   assign evt.wrByte = hostDataIn;
endmodule : kbc_host_decode

// >>> kbc_host_mailbox.sv
// Summary of operation
// [R1] data write loads input, clears cmd flag
// [R2] command write loads input, sets cmd flag
// [R3] data read returns output; gated clears flags
// [R4] ungated: firmware clears interrupt flags itself
// [R5] control read returns status, no side effects
// [R6] three separate eight bit registers
// [R7] cpu buffer write sets output full
// [R8] host write copies address bit two
// [R9] gated keyboard irq follows output full
// [R10] keyboard irq low after reset
// [R11] ungated keyboard irq follows port bit
// [R12] gated aux irq is inverted input full
// [R13] ungated aux irq follows port bit
// [R14] port bit drives gate a20
// [R15] cpu input read clears input full
// [R16] status cleared to zero by reset
// [R17] user status bits written by cpu
// [R18] write while full overwrites, stays full
`include "kbc_defines.svh"
module kbc_host_mailbox (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // isa host side
   input  wire kbc_pkg::ioaddr_t hostAddr,
   input  wire logic             ioRead_n,
   input  wire logic             ioWrite_n,
   input  wire kbc_pkg::byte_t   hostDataIn,
   output logic     [7:0]        hostDataOut,
   // embedded cpu side
   input  wire logic             cpuBufWrite,
   input  wire kbc_pkg::byte_t   cpuBufWrData,
   input  wire logic             cpuBufRead,
   output logic     [7:0]        cpuBufRdData,
   input  wire logic             cpuStatusWrite,
   input  wire kbc_pkg::byte_t   cpuStatusWrData,
   output logic     [7:0]        cpuStatusRdData,
   input  wire logic             enFlags,
   input  wire logic             portWrite,
   input  wire logic             kbdIrqPortBit,
   input  wire logic             auxIrqPortBit,
   input  wire logic             a20PortBit,
   input  wire logic             auxFullClear,
   // outputs
   output logic                  keyboardHostIrq,
   output logic                  auxHostIrq,
   output logic                  gateA20,
   output logic                  auxOutputFull
);
   import kbc_pkg::*;

   kbc_host_if evt ();

   kbc_host_decode u_decode (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .hostAddr   (hostAddr),
      .ioRead_n   (ioRead_n),
      .ioWrite_n  (ioWrite_n),
      .hostDataIn (hostDataIn),
      .evt        (evt)
   );

   byte_t inReg_r;
   byte_t outReg_r;
   byte_t status_r;
   byte_t status_nxt;
   logic  flagsOn_r;
   logic  kbdBit_r;
   logic  auxBit_r;
   logic  kbdIrq_nxt;
   logic  auxIrq_nxt;
   logic  hostWr;
   logic  hostRdCtrl;

   assign hostWr     = evt.wrData || evt.wrCmd;
   assign hostRdCtrl = !ioRead_n && ioWrite_n && (hostAddr == `KBC_CTRL_ADDR);

   // input register; a write while full simply overwrites
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         inReg_r <= `KBC_BYTE_RESET;
      end else if (hostWr) begin
         inReg_r <= evt.wrByte; // [R1] [R2] [R18]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         outReg_r <= `KBC_BYTE_RESET;
      end else if (cpuBufWrite) begin
         outReg_r <= cpuBufWrData;
      end
   end

   // port bits latched from firmware writes; gating mode follows enFlags every cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flagsOn_r <= 1'b0;
         kbdBit_r  <= 1'b0;
         auxBit_r  <= 1'b0;
         gateA20   <= 1'b0;
      end else begin
         flagsOn_r <= enFlags;
         if (portWrite) begin
            kbdBit_r <= kbdIrqPortBit;
            auxBit_r <= auxIrqPortBit;
            gateA20  <= a20PortBit; // [R14]
         end
      end
   end

   // status: sets from hardware events win over clears
   always_comb begin
      status_nxt = status_r;
      if (cpuStatusWrite) begin
         status_nxt = (status_r & ~`KBC_UD_MASK) | (cpuStatusWrData & `KBC_UD_MASK); // [R17]
      end
      if (evt.rdData && flagsOn_r) begin
         status_nxt[`KBC_OBF_BIT] = 1'b0; // [R3]
      end
      if (cpuBufRead) begin
         status_nxt[`KBC_IBF_BIT] = 1'b0; // [R15]
      end
      if (cpuBufWrite) begin
         status_nxt[`KBC_OBF_BIT] = 1'b1; // [R7]
      end
      if (hostWr) begin
         status_nxt[`KBC_IBF_BIT] = 1'b1; // [R1] [R2] [R18]
         status_nxt[`KBC_CD_BIT]  = hostAddr[`KBC_ADDR_CD_BIT]; // [R8]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_r <= `KBC_STATUS_RESET; // [R16]
      end else begin
         status_r <= status_nxt;
      end
   end

   // gated irq outputs computed from next status so they stay registered; ungated ones follow the latched port bits
   always_comb begin
      if (flagsOn_r) begin
         kbdIrq_nxt = kbdBit_r && status_nxt[`KBC_OBF_BIT]; // [R9]
         auxIrq_nxt = auxBit_r && !status_nxt[`KBC_IBF_BIT]; // [R12]
      end else begin
         kbdIrq_nxt = kbdBit_r; // [R11] [R4]
         auxIrq_nxt = auxBit_r; // [R13]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         keyboardHostIrq <= 1'b0; // [R10]
         auxHostIrq      <= 1'b0;
      end else begin
         keyboardHostIrq <= kbdIrq_nxt;
         auxHostIrq      <= auxIrq_nxt;
      end
   end

   // aux full flag: firmware clears it when ungated
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         auxOutputFull <= 1'b0;
      end else if (cpuBufWrite) begin
         auxOutputFull <= 1'b1;
      end else if (auxFullClear || (flagsOn_r && evt.rdData)) begin
         auxOutputFull <= 1'b0; // [R4]
      end
   end

   // host read data; status read has no side effect
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hostDataOut <= `KBC_BYTE_RESET;
      end else if (hostRdCtrl) begin
         hostDataOut <= status_r; // [R5] [R6]
      end else begin
         hostDataOut <= outReg_r; // [R3] [R6]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpuBufRdData    <= `KBC_BYTE_RESET;
         cpuStatusRdData <= `KBC_BYTE_RESET;
      end else begin
         cpuBufRdData    <= inReg_r;
         cpuStatusRdData <= status_nxt;
      end
   end
endmodule : kbc_host_mailbox

// >>> kbc_properties.sv
module kbc_properties (
   input wire logic core_clk, rst_n, ioRead_n, ioWrite_n, cpuBufWrite, enFlags, portWrite,
   input wire logic kbdIrqPortBit, auxIrqPortBit, a20PortBit, keyboardHostIrq, auxHostIrq,
   input wire logic gateA20,
   input wire kbc_pkg::ioaddr_t hostAddr,
   input wire kbc_pkg::byte_t hostDataIn, cpuBufWrData,
   input wire logic [7:0] hostDataOut, cpuBufRdData, cpuStatusRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   logic kp_r, ap_r;
   byte_t out_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // mirrors of cpu-side latches the ports hide
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         {kp_r, ap_r, out_r} <= 10'h000;
      end else begin
         if (portWrite) {kp_r, ap_r} <= {kbdIrqPortBit, auxIrqPortBit};
         if (cpuBufWrite) out_r <= cpuBufWrData;
      end
   end
   property p_rst; $rose(rst_n) |-> !keyboardHostIrq && cpuStatusRdData == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("irq or status set after reset");
   property p_wr;
      $fell(ioWrite_n) && ioRead_n && hostAddr inside {16'h0060, 16'h0064}
         |-> ##2 cpuBufRdData == $past(hostDataIn, 2);
   endproperty
   a_wr: assert property (p_wr) else $error("host write not loaded");
   property p_rd; $fell(ioRead_n) && hostAddr == 16'h0060 |=> hostDataOut == $past(out_r);
   endproperty
   a_rd: assert property (p_rd) else $error("data read wrong");
   property p_kset; cpuBufWrite && enFlags && $past(enFlags) && kp_r |-> ##[1:2] keyboardHostIrq;
   endproperty
   a_kset: assert property (p_kset) else $error("gated irq not raised");
   property p_klow; (enFlags && !kp_r) [*3] |-> !keyboardHostIrq; endproperty
   a_klow: assert property (p_klow) else $error("gated irq not forced low");
   property p_kopen; !enFlags [*3] ##0 keyboardHostIrq != kp_r |=> keyboardHostIrq == kp_r;
   endproperty
   a_kopen: assert property (p_kopen) else $error("ungated kbd irq");
   property p_aopen; !enFlags [*3] ##0 auxHostIrq != ap_r |=> auxHostIrq == ap_r; endproperty
   a_aopen: assert property (p_aopen) else $error("ungated aux irq");
   property p_a20; portWrite |=> gateA20 == $past(a20PortBit); endproperty
   a_a20: assert property (p_a20) else $error("gate a20 lags");
   c_out: cover property (cpuBufWrite && enFlags);
   c_cmd: cover property ($fell(ioWrite_n) && hostAddr == 16'h0064);
   c_open: cover property (portWrite && !enFlags);
endmodule : kbc_properties

// >>> host_bus.sv
module host_bus (
   input  wire logic        core_clk,
   input  wire logic [7:0]  hostDataOut,
   output kbc_pkg::ioaddr_t hostAddr,
   output logic             ioRead_n,
   output logic             ioWrite_n,
   output kbc_pkg::byte_t   hostDataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   // both strobes idle high
   initial begin
      {hostAddr, ioRead_n, ioWrite_n, hostDataIn} = 26'h0000300;
   end
   // released bus shows inverse data so stale bytes never match
   task wr(input ioaddr_t a, input byte_t d);
      @(negedge core_clk);
      {hostAddr, hostDataIn, ioWrite_n} = {a, d, 1'b0};
      @(negedge core_clk);
      {hostDataIn, ioWrite_n} = {~d, 1'b1};
      @(negedge core_clk);
   endtask : wr
   task rd(input ioaddr_t a, output byte_t d);
      @(negedge core_clk);
      {hostAddr, ioRead_n} = {a, 1'b0};
      repeat (2) @(negedge core_clk);
      d = hostDataOut;
      ioRead_n = 1'b1;
      @(negedge core_clk);
   endtask : rd
endmodule : host_bus

// >>> tb_kbc_host_mailbox.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_kbc_host_mailbox;
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   logic core_clk, rst_n, ioRead_n, ioWrite_n, cpuBufWrite, cpuBufRead, cpuStatusWrite;
   logic enFlags, portWrite, kbdIrqPortBit, auxIrqPortBit, a20PortBit, auxFullClear;
   logic keyboardHostIrq, auxHostIrq, gateA20, auxOutputFull;
   ioaddr_t hostAddr;
   byte_t hostDataIn, cpuBufWrData, cpuStatusWrData, d;
   logic [7:0] hostDataOut, cpuBufRdData, cpuStatusRdData;
   int errors = 0, tests_run = 0;
   kbc_host_mailbox kbc_host_mailbox_i (.core_clk, .rst_n, .hostAddr, .ioRead_n, .ioWrite_n,
      .hostDataIn, .hostDataOut, .cpuBufWrite, .cpuBufWrData, .cpuBufRead, .cpuBufRdData,
      .cpuStatusWrite, .cpuStatusWrData, .cpuStatusRdData, .enFlags, .portWrite, .kbdIrqPortBit,
      .auxIrqPortBit, .a20PortBit, .auxFullClear, .keyboardHostIrq, .auxHostIrq, .gateA20,
      .auxOutputFull);
   host_bus host_bus_i (.core_clk, .hostDataOut, .hostAddr, .ioRead_n, .ioWrite_n, .hostDataIn);
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   task end_of_test;
      $display("TB: %0d checks, %0d errors", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task tick(int n); repeat (n) @(negedge core_clk); endtask : tick
   task port(logic k, logic a, logic g);
      {kbdIrqPortBit, auxIrqPortBit, a20PortBit, portWrite} = {k, a, g, 1'b1};
      tick(1);
      portWrite = 0;
      tick(2);
   endtask : port
   task cpu_wr(byte_t v);
      {cpuBufWrData, cpuBufWrite} = {v, 1'b1};
      tick(1);
      cpuBufWrite = 0;
      tick(2);
   endtask : cpu_wr
   task stat(byte_t e); host_bus_i.rd(16'h0064, d); `CHK(d, e) endtask : stat
   task t_host_in;
      stat(8'h00);
      enFlags = 1;
      port(1, 1, 1);
      `CHK({gateA20, auxHostIrq, keyboardHostIrq}, 3'h6)
      host_bus_i.wr(16'h0060, 8'hA5);
      `CHK(auxHostIrq, 1'b0)
      stat(8'h02);
      `CHK(cpuStatusRdData, 8'h02)
      host_bus_i.wr(16'h0064, 8'h3C);
      stat(8'h0A);
      `CHK(cpuBufRdData, 8'h3C)
      host_bus_i.wr(16'h0061, 8'hFF);
      {cpuBufRead, d} = {1'b1, 8'h00};
      tick(1);
      cpuBufRead = 0;
      tick(2);
      stat(8'h08);
      `CHK({auxHostIrq, cpuBufRdData}, 9'h13C)
      $display("TB: host to cpu done");
   endtask : t_host_in
   task t_cpu_out;
      cpu_wr(8'h5A);
      stat(8'h09);
      `CHK(keyboardHostIrq, 1'b1)
      `CHK(auxOutputFull, 1'b1)
      host_bus_i.rd(16'h0060, d);
      `CHK({d, keyboardHostIrq}, 9'h0B4)
      `CHK(auxOutputFull, 1'b0)
      stat(8'h08);
      port(0, 1, 0);
      cpu_wr(8'h77);
      `CHK({keyboardHostIrq, gateA20}, 2'h0)
      {cpuStatusWrData, cpuStatusWrite} = {8'hFF, 1'b1};
      tick(1);
      cpuStatusWrite = 0;
      stat(8'hFD);
      $display("TB: cpu to host done");
   endtask : t_cpu_out
   task t_open;
      enFlags = 0;
      port(1, 0, 0);
      `CHK({keyboardHostIrq, auxHostIrq}, 2'h2)
      port(0, 1, 0);
      `CHK({keyboardHostIrq, auxHostIrq}, 2'h1)
      port(1, 1, 0);
      host_bus_i.rd(16'h0060, d);
      `CHK({d, keyboardHostIrq, auxOutputFull}, 10'h1DF)
      stat(8'hFD);
      auxFullClear = 1;
      tick(1);
      auxFullClear = 0;
      tick(1);
      `CHK(auxOutputFull, 1'b0)
      $display("TB: ungated done");
   endtask : t_open
   task t_reset;
      rst_n = 0;
      tick(2);
      rst_n = 1;
      `CHK({keyboardHostIrq, auxHostIrq, gateA20, auxOutputFull}, 4'h0)
      stat(8'h00);
      $display("TB: mid-run reset done");
   endtask : t_reset
   initial begin
      {rst_n, cpuBufWrite, cpuBufRead, cpuStatusWrite, enFlags, portWrite} = 6'h00;
      {kbdIrqPortBit, auxIrqPortBit, a20PortBit, auxFullClear} = 4'h0;
      {cpuBufWrData, cpuStatusWrData} = 16'h0000;
      tick(10);
      rst_n = 1;
      t_host_in;
      t_cpu_out;
      t_open;
      t_reset;
      end_of_test;
   end
   initial begin
      #5000;
      errors++;
      end_of_test;
   end
endmodule : tb_kbc_host_mailbox
bind kbc_host_mailbox kbc_properties kbc_properties_i (.core_clk, .rst_n, .ioRead_n, .ioWrite_n,
   .cpuBufWrite, .enFlags, .portWrite, .kbdIrqPortBit, .auxIrqPortBit, .a20PortBit,
   .keyboardHostIrq, .auxHostIrq, .gateA20, .hostAddr, .hostDataIn, .cpuBufWrData,
   .hostDataOut, .cpuBufRdData, .cpuStatusRdData);
